/* hdl/codec_mailbox_device.sv */
// Device end of the codec mailbox: block storage, code registers,
// handshake service and the three-frame settings pipeline.
// Assumes the host end drives the port from the same clock.
`timescale 1ns/1ps

// How it works
// - Host requests status by writing code 33
// - Device copies status, clears flag, posts 34
// - Host reads status; clearing device flag optional
// - Host acknowledges by writing code 35
// - Acknowledge sets host request flag; device clears it, posts nothing
// - Settings reach status after three frames
// - Control and status share one layout
// - Nine byte words in fixed order
// - Host holds neutral three frames before changes
// - Reset starts in neutral mode
// - Word 0 resets c1, bits 3:0 fixed
// - Protocol bit: 0 outband, 1 inband
// - Frame length bit 0 selects 10 ms
// - Word 1 bits 4:3 pick sample format
// - Word 1 bit 2 zeroes excitation
// - Word 1 bit 0 enables postfilter
// - Word 2 resets c0, highpass and postfilter
// - Word 3 bit 7 enables wideband test
// - Word 4 nibbles hold encoder, decoder modes
// - Neutral mode stops compressed data exchange
module codec_mailbox_device
   import codec_mailbox_pkg::*;
#(
   parameter int unsigned FRAME_CYCLES_P = FRAME_CYCLES
) (
   codec_mailbox_if.device       bus,
   input  wire logic             clock,
   input  wire logic             rst_n,
   output logic                  frame_tick,
   output logic                  protocol_inband,
   output logic [1:0]            interface_routing,
   output logic                  uncompressed_on_tdm,
   output logic                  compressed_on_serial,
   output logic                  frame_length_select,
   output logic [1:0]            sample_format,
   output logic                  excitation_zero,
   output logic                  low_delay_postfilter_on,
   output logic                  highpass_enable,
   output logic                  multirate_postfilter_on,
   output logic                  wideband_test_mode,
   output logic [3:0]            encoder_mode_code,
   output logic [3:0]            decoder_mode_code,
   output logic                  encoder_data_enable,
   output logic                  decoder_data_enable,
   output logic [7:0]            packet_loopback_options,
   output logic [7:0]            sample_rate_options,
   output logic [7:0]            encoder_volume,
   output logic [7:0]            decoder_volume
);

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   logic [8:0][7:0] mbox_q;
   logic [8:0][7:0] pend_q;
   logic [8:0][7:0] stage1_q;
   logic [8:0][7:0] stage2_q;
   logic [8:0][7:0] eff_q;
   logic [7:0]      h2d_code_q;
   logic [7:0]      d2h_code_q;
   logic            host_request_flag_q;
   logic            irq_n_q;
   logic [7:0]      rdata_q;
   logic [31:0]     frame_cnt_q;
   logic            tick_q;
   logic            enc_en_q;
   logic            dec_en_q;
   logic            tdm_q;
   logic            serial_q;

   logic            wr_mbox;
   logic            wr_h2d;
   logic            wr_d2h;
   logic            svc;
   logic            svc_status;
   logic            svc_ctrl;
   logic            post_ack;

   assign wr_mbox    = bus.wr && (bus.addr < 8'(BLOCK_WORDS));
   assign wr_h2d     = bus.wr && (bus.addr == H2D_CODE_OFS);
   assign wr_d2h     = bus.wr && (bus.addr == D2H_CODE_OFS);
   // One request is served per cycle the flag stands
   assign svc        = host_request_flag_q;
   assign svc_status = svc && (h2d_code_q == CODE_STATUS_REQ);
   assign svc_ctrl   = svc && (h2d_code_q == CODE_CTRL_WRITE);
   assign post_ack   = svc_status || svc_ctrl;

   // -----------------------------------------------------------------
   // Host request flag and code register
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         h2d_code_q          <= CODE_NONE;
         host_request_flag_q <= 1'b0;
      end else begin
         if (wr_h2d) begin
            h2d_code_q <= bus.wdata;
         end
         // A new host write wins over the service clear
         if (wr_h2d) begin
            host_request_flag_q <= 1'b1;
         end else if (svc) begin
            host_request_flag_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Device-to-host code and interrupt line
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         d2h_code_q <= CODE_NONE;
         irq_n_q    <= 1'b1;
      end else begin
         if (post_ack) begin
            d2h_code_q <= svc_status ? CODE_STATUS_RDY : CODE_CTRL_ACK;
            irq_n_q    <= 1'b0;
         end else if (wr_d2h) begin
            // Host clear is optional; nothing waits on it
            d2h_code_q <= bus.wdata;
            irq_n_q    <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Mailbox
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mbox_q <= BLOCK_RESET;
      end else if (svc_status) begin
         mbox_q <= eff_q;
      end else if (wr_mbox) begin
         mbox_q[bus.addr[3:0]] <= bus.wdata;
      end
   end

   // Control block taken from the mailbox, fixed bits forced
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= BLOCK_RESET;
      end else if (svc_ctrl) begin
         for (int i = 0; i < BLOCK_WORDS; i++) begin
            pend_q[i] <= sanitize(i, mbox_q[i]);
         end
      end
   end

   // -----------------------------------------------------------------
   // Frame divider and settings pipeline
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         frame_cnt_q <= 32'h0;
         tick_q      <= 1'b0;
      end else if (frame_cnt_q == FRAME_CYCLES_P - 1) begin
         frame_cnt_q <= 32'h0;
         tick_q      <= 1'b1;
      end else begin
         frame_cnt_q <= frame_cnt_q + 32'h1;
         tick_q      <= 1'b0;
      end
   end

   // Input, coding and output stages, one frame each
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage1_q <= BLOCK_RESET;
         stage2_q <= BLOCK_RESET;
         eff_q    <= BLOCK_RESET;
      end else if (tick_q) begin
         stage1_q <= pend_q;
         stage2_q <= stage1_q;
         eff_q    <= stage2_q;
      end
   end

   // Decoded flags kept in flops; reset low, in step with eff_q from the first frame tick
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         enc_en_q <= 1'b0;
         dec_en_q <= 1'b0;
         tdm_q    <= 1'b0;
         serial_q <= 1'b0;
      end else if (tick_q) begin
         enc_en_q <= stage2_q[MODE_OFS][ENC_MODE_LSB +: 4] != MODE_NEUTRAL;
         dec_en_q <= stage2_q[MODE_OFS][DEC_MODE_LSB +: 4] != MODE_NEUTRAL;
         tdm_q    <= stage2_q[PROTO_IF_CTRL_OFS][ROUTE_LSB +: 2] == ROUTE_TDM_HOST
                  || stage2_q[PROTO_IF_CTRL_OFS][ROUTE_LSB +: 2] == ROUTE_TDM_SERIAL;
         serial_q <= stage2_q[PROTO_IF_CTRL_OFS][ROUTE_LSB +: 2] == ROUTE_TDM_SERIAL;
      end
   end

   // -----------------------------------------------------------------
   // Read path, data one cycle after the strobe
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         if (bus.addr < 8'(BLOCK_WORDS)) begin
            rdata_q <= mbox_q[bus.addr[3:0]];
         end else if (bus.addr == H2D_CODE_OFS) begin
            rdata_q <= h2d_code_q;
         end else if (bus.addr == D2H_CODE_OFS) begin
            rdata_q <= d2h_code_q;
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign bus.rdata = rdata_q;
   assign bus.irq_n = irq_n_q;

   // -----------------------------------------------------------------
   // Settings in effect
   // -----------------------------------------------------------------
   assign frame_tick              = tick_q;
   assign protocol_inband         = eff_q[PROTO_IF_CTRL_OFS][PSEL_BIT];
   assign interface_routing       = eff_q[PROTO_IF_CTRL_OFS][ROUTE_LSB +: 2];
   assign uncompressed_on_tdm     = tdm_q;
   assign compressed_on_serial    = serial_q;
   assign frame_length_select     = eff_q[PROTO_IF_CTRL_OFS][FRAME_LENGTH_SELECT_BIT];
   assign sample_format           = eff_q[LD_OPTIONS_OFS][UDF_LSB +: 2];
   assign excitation_zero         = eff_q[LD_OPTIONS_OFS][ET_ZERO_BIT];
   assign low_delay_postfilter_on = eff_q[LD_OPTIONS_OFS][LD_PF_BIT];
   assign highpass_enable         = eff_q[MR_OPTIONS_OFS][HP_BIT];
   assign multirate_postfilter_on = eff_q[MR_OPTIONS_OFS][MR_PF_BIT];
   assign wideband_test_mode      = eff_q[WB_OPTIONS_OFS][WB_TEST_BIT];
   assign encoder_mode_code       = eff_q[MODE_OFS][ENC_MODE_LSB +: 4];
   assign decoder_mode_code       = eff_q[MODE_OFS][DEC_MODE_LSB +: 4];
   assign encoder_data_enable     = enc_en_q;
   assign decoder_data_enable     = dec_en_q;
   assign packet_loopback_options = eff_q[LOOPBACK_OPT_OFS];
   assign sample_rate_options     = eff_q[RATE_OPT_OFS];
   assign encoder_volume          = eff_q[ENC_VOLUME_OFS];
   assign decoder_volume          = eff_q[DEC_VOLUME_OFS];

endmodule : codec_mailbox_device

/* hdl/codec_mailbox_host.sv */
// Host end: runs the status read and control write handshakes for software.
// Assumes the device end on the same clock and the plain software port.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module codec_mailbox_host
   import codec_mailbox_pkg::*;
#(
   parameter int unsigned FRAME_CYCLES_P = FRAME_CYCLES
) (
   codec_mailbox_if.host   bus,
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [7:0] sw_addr,
   input  wire logic [7:0] sw_wdata,
   input  wire logic       sw_wr,
   input  wire logic       sw_rd,
   output logic [7:0]      sw_rdata
);

   // -----------------------------------------------------------------
   // Neutral hold length and sequencer states
   // -----------------------------------------------------------------
   localparam int unsigned HOLD_CYCLES = NEUTRAL_FRAMES * FRAME_CYCLES_P;

   typedef enum logic [3:0] {
      S_IDLE     = 4'h0,
      S_NEU_MB   = 4'h1,
      S_NEU_KICK = 4'h2,
      S_NEU_WAIT = 4'h3,
      S_NEU_CLR  = 4'h4,
      S_HOLD     = 4'h5,
      S_WR_BYTE  = 4'h6,
      S_WR_KICK  = 4'h7,
      S_WR_WAIT  = 4'h8,
      S_WR_CLR   = 4'h9,
      S_RQ_KICK  = 4'ha,
      S_RQ_WAIT  = 4'hb,
      S_RD       = 4'hc,
      S_RQ_CLR   = 4'hd,
      S_RQ_ACK   = 4'he
   } host_state_t;

   host_state_t     state_q;
   logic [8:0][7:0] ctl_q;
   logic [8:0][7:0] stat_q;
   logic [7:0]      addr_q;
   logic [7:0]      wdata_q;
   logic            wr_q;
   logic            rd_q;
   logic [3:0]      idx_q;
   logic [31:0]     hold_q;
   logic            cap_q;
   logic [3:0]      cap_idx_q;
   logic            done_q;
   logic [7:0]      sw_rdata_q;
   logic            go_status;
   logic            go_ctrl;
   logic            finish;

   assign go_status = sw_wr && sw_addr == CMD_OFS && sw_wdata[0];
   assign go_ctrl   = sw_wr && sw_addr == CMD_OFS && sw_wdata[1];
   assign finish    = (state_q == S_WR_CLR) || (state_q == S_RQ_ACK);

   // -----------------------------------------------------------------
   // Handshake sequencer and port drive
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         addr_q  <= 8'h00;
         wdata_q <= 8'h00;
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         idx_q   <= 4'h0;
         hold_q  <= 32'h0;
      end else begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               idx_q <= 4'h0;
               if (go_ctrl) begin
                  state_q <= S_NEU_MB;
               end else if (go_status) begin
                  state_q <= S_RQ_KICK;
               end
            end
            S_NEU_MB: begin
               // Neutral mode may be sent at any time
               {wr_q, addr_q, wdata_q} <= {1'b1, MODE_OFS, 8'h00};
               state_q <= S_NEU_KICK;
            end
            S_NEU_KICK: begin
               {wr_q, addr_q, wdata_q} <= {1'b1, H2D_CODE_OFS, CODE_CTRL_WRITE};
               state_q <= S_NEU_WAIT;
            end
            S_NEU_WAIT: begin
               if (!bus.irq_n) begin
                  state_q <= S_NEU_CLR;
               end
            end
            S_NEU_CLR: begin
               {wr_q, addr_q, wdata_q} <= {1'b1, D2H_CODE_OFS, CODE_NONE};
               hold_q  <= 32'h0;
               state_q <= S_HOLD;
            end
            S_HOLD: begin
               hold_q <= hold_q + 32'h1;
               if (hold_q == HOLD_CYCLES - 1) begin
                  state_q <= S_WR_BYTE;
               end
            end
            S_WR_BYTE: begin
               {wr_q, addr_q, wdata_q} <= {1'b1, 4'h0, idx_q, ctl_q[idx_q]};
               idx_q <= idx_q + 4'h1;
               if (idx_q == 4'(BLOCK_WORDS - 1)) begin
                  state_q <= S_WR_KICK;
               end
            end
            S_WR_KICK: begin
               {wr_q, addr_q, wdata_q} <= {1'b1, H2D_CODE_OFS, CODE_CTRL_WRITE};
               state_q <= S_WR_WAIT;
            end
            S_WR_WAIT: begin
               if (!bus.irq_n) begin
                  state_q <= S_WR_CLR;
               end
            end
            S_WR_CLR: begin
               {wr_q, addr_q, wdata_q} <= {1'b1, D2H_CODE_OFS, CODE_NONE};
               state_q <= S_IDLE;
            end
            S_RQ_KICK: begin
               {wr_q, addr_q, wdata_q} <= {1'b1, H2D_CODE_OFS, CODE_STATUS_REQ};
               state_q <= S_RQ_WAIT;
            end
            S_RQ_WAIT: begin
               if (!bus.irq_n) begin
                  state_q <= S_RD;
               end
            end
            S_RD: begin
               {rd_q, addr_q} <= {1'b1, 4'h0, idx_q};
               idx_q <= idx_q + 4'h1;
               if (idx_q == 4'(BLOCK_WORDS - 1)) begin
                  state_q <= S_RQ_CLR;
               end
            end
            S_RQ_CLR: begin
               // Clearing is optional; done so the line idles high
               {wr_q, addr_q, wdata_q} <= {1'b1, D2H_CODE_OFS, CODE_NONE};
               state_q <= S_RQ_ACK;
            end
            S_RQ_ACK: begin
               {wr_q, addr_q, wdata_q} <= {1'b1, H2D_CODE_OFS, CODE_STATUS_ACK};
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Status capture, one cycle after each read strobe
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cap_q     <= 1'b0;
         cap_idx_q <= 4'h0;
         stat_q    <= BLOCK_RESET;
      end else begin
         cap_q     <= rd_q;
         cap_idx_q <= addr_q[3:0];
         if (cap_q) begin
            stat_q[cap_idx_q] <= bus.rdata;
         end
      end
   end

   // -----------------------------------------------------------------
   // Software registers
   // -----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q  <= BLOCK_RESET;
         done_q <= 1'b0;
      end else begin
         if (sw_wr && sw_addr < 8'(BLOCK_WORDS)) begin
            ctl_q[sw_addr[3:0]] <= sw_wdata;
         end
         // Completion wins over a software clear
         if (finish) begin
            done_q <= 1'b1;
         end else if (sw_wr && sw_addr == STAT_OFS && sw_wdata[1]) begin
            done_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sw_rdata_q <= 8'h00;
      end else if (sw_rd) begin
         if (sw_addr < 8'(BLOCK_WORDS)) begin
            sw_rdata_q <= ctl_q[sw_addr[3:0]];
         end else if (sw_addr == STAT_OFS) begin
            sw_rdata_q <= {5'h0, !bus.irq_n, done_q, state_q != S_IDLE};
         end else if (sw_addr >= READ_BASE && sw_addr < READ_BASE + 8'(BLOCK_WORDS)) begin
            sw_rdata_q <= stat_q[sw_addr[3:0]];
         end else begin
            sw_rdata_q <= 8'h00;
         end
      end
   end

   assign bus.addr  = addr_q;
   assign bus.wdata = wdata_q;
   assign bus.wr    = wr_q;
   assign bus.rd    = rd_q;
   assign sw_rdata  = sw_rdata_q;

endmodule : codec_mailbox_host

/* hdl/codec_mailbox_if.sv */
// Parallel host port between host controller and codec device.
// Assumes both ends run on the same clock; read data follow a read by one cycle.
`timescale 1ns/1ps
interface codec_mailbox_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       irq_n;

   modport device (input addr, input wdata, input wr, input rd, output rdata, output irq_n);
   modport host   (output addr, output wdata, output wr, output rd, input rdata, input irq_n);
endinterface : codec_mailbox_if

/* hdl/codec_mailbox_pkg.sv */
// Constants shared by both ends of the codec control/status mailbox.
// Assumes one 200 MHz clock shared by host and device logic.
package codec_mailbox_pkg;

   // -----------------------------------------------------------------
   // Clock and frame timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 5;
   localparam int unsigned FRAME_TIME_US  = 10000;
   localparam int unsigned FRAME_CYCLES   = FRAME_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned PIPE_FRAMES    = 3;
   localparam int unsigned NEUTRAL_FRAMES = 3;

   // -----------------------------------------------------------------
   // Address map of the device
   // -----------------------------------------------------------------
   localparam int unsigned BLOCK_WORDS       = 9;
   localparam logic [7:0]  PROTO_IF_CTRL_OFS = 8'h00;
   localparam logic [7:0]  LD_OPTIONS_OFS    = 8'h01;
   localparam logic [7:0]  MR_OPTIONS_OFS    = 8'h02;
   localparam logic [7:0]  WB_OPTIONS_OFS    = 8'h03;
   localparam logic [7:0]  MODE_OFS          = 8'h04;
   localparam logic [7:0]  LOOPBACK_OPT_OFS  = 8'h05;
   localparam logic [7:0]  RATE_OPT_OFS      = 8'h06;
   localparam logic [7:0]  ENC_VOLUME_OFS    = 8'h07;
   localparam logic [7:0]  DEC_VOLUME_OFS    = 8'h08;
   localparam logic [7:0]  H2D_CODE_OFS      = 8'h50;
   localparam logic [7:0]  D2H_CODE_OFS      = 8'h58;
   // Software port of the host end
   localparam logic [7:0]  CMD_OFS           = 8'h10;
   localparam logic [7:0]  STAT_OFS          = 8'h11;
   localparam logic [7:0]  READ_BASE         = 8'h20;

   // -----------------------------------------------------------------
   // Handshake codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CODE_CTRL_WRITE = 8'h31;
   localparam logic [7:0] CODE_CTRL_ACK   = 8'h32;
   localparam logic [7:0] CODE_STATUS_REQ = 8'h33;
   localparam logic [7:0] CODE_STATUS_RDY = 8'h34;
   localparam logic [7:0] CODE_STATUS_ACK = 8'h35;
   localparam logic [7:0] CODE_NONE       = 8'h00;

   // -----------------------------------------------------------------
   // Block layout: byte i is element [i]
   // -----------------------------------------------------------------
   localparam logic [8:0][7:0] BLOCK_RESET =
      {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h02, 8'hc1};
   localparam logic [8:0][7:0] BLOCK_KEEP =
      {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h80, 8'hc0, 8'h1d, 8'hf0};
   localparam logic [8:0][7:0] BLOCK_FORCE =
      {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01};

   localparam int unsigned PSEL_BIT      = 7;
   localparam int unsigned ROUTE_LSB     = 5;
   localparam int unsigned FRAME_LENGTH_SELECT_BIT      = 4;
   localparam int unsigned UDF_LSB       = 3;
   localparam int unsigned ET_ZERO_BIT   = 2;
   localparam int unsigned LD_PF_BIT     = 0;
   localparam int unsigned HP_BIT        = 7;
   localparam int unsigned MR_PF_BIT     = 6;
   localparam int unsigned WB_TEST_BIT   = 7;
   localparam int unsigned ENC_MODE_LSB  = 4;
   localparam int unsigned DEC_MODE_LSB  = 0;
   localparam logic [3:0]  MODE_NEUTRAL  = 4'h0;

   localparam logic [1:0] ROUTE_ALL_HOST   = 2'h0;
   localparam logic [1:0] ROUTE_TDM_HOST   = 2'h1;
   localparam logic [1:0] ROUTE_TDM_SERIAL = 2'h2;

   // Fixed bits are forced so that status always reads them right
   function automatic logic [7:0] sanitize(input int unsigned idx, input logic [7:0] v);
      sanitize = (v & BLOCK_KEEP[idx]) | BLOCK_FORCE[idx];
   endfunction : sanitize

endpackage : codec_mailbox_pkg

/* verification/codec_control_status_mailbox_tb.sv */
// Bench for host and device ends joined by the mailbox interface.
// Assumes short frames so the three-frame pipeline runs quickly.
`timescale 1ns/1ps
module codec_control_status_mailbox_tb;
   import codec_mailbox_pkg::*;
   localparam int FC = 20;
   logic       clock = 0, rst_n = 0, sw_wr = 0, sw_rd = 0, tdm, ser, tick, enc_en, dec_en;
   logic [7:0] sw_addr = 0, sw_wdata = 0, sw_rdata, v, b;
   wire  [8:0][7:0] w;
   logic [7:0] blk [9] = '{8'hc1, 8'h02, 8'hc0, 0, 0, 0, 0, 0, 0};
   int         n_mismatch = 0, samples_checked = 0, cyc = 0, seed = 32'h44f3, last = 0;
   codec_mailbox_if bus ();
   codec_mailbox_host #(.FRAME_CYCLES_P(FC)) codec_mailbox_host_i (.bus(bus.host),
      .clock(clock), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
      .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   codec_mailbox_device #(.FRAME_CYCLES_P(FC)) codec_mailbox_device_i (.bus(bus.device),
      .clock(clock), .rst_n(rst_n), .frame_tick(tick), .protocol_inband(w[0][7]),
      .interface_routing(w[0][6:5]), .uncompressed_on_tdm(tdm), .compressed_on_serial(ser),
      .frame_length_select(w[0][4]), .sample_format(w[1][4:3]), .excitation_zero(w[1][2]),
      .low_delay_postfilter_on(w[1][0]), .highpass_enable(w[2][7]),
      .multirate_postfilter_on(w[2][6]), .wideband_test_mode(w[3][7]),
      .encoder_mode_code(w[4][7:4]), .decoder_mode_code(w[4][3:0]),
      .encoder_data_enable(enc_en), .decoder_data_enable(dec_en),
      .packet_loopback_options(w[5]), .sample_rate_options(w[6]), .encoder_volume(w[7]),
      .decoder_volume(w[8]));
   // Fixed bits have no output; tied low and masked in the compare
   assign {w[0][3:0], w[1][7:5], w[1][1], w[2][5:0], w[3][6:0]} = '0;
   codec_mailbox_props codec_mailbox_props_i (.clock(clock), .rst_n(rst_n), .addr(bus.addr),
      .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .irq_n(bus.irq_n));

   always #2.5 clock = !clock;

   // --------------------------------------------------------------
   // Software port tasks and block model
   // --------------------------------------------------------------
   task automatic sw(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sw_wr <= w;
      sw_rd <= !w;
      sw_addr <= a;
      sw_wdata <= d;
      @(posedge clock);
      sw_wr <= 1'b0;
      sw_rd <= 1'b0;
      #1 v = sw_rdata;
   endtask : sw

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   // Command then poll until done; a hang is caught by the cycle ceiling
   task automatic run(input logic [7:0] c);
      sw(1'b1, 8'h10, c);
      v = 8'h00;
      while (!v[1]) sw(1'b0, 8'h11, 8'h00);
      sw(1'b1, 8'h11, 8'h02);
   endtask : run

   task automatic status_check;
      run(8'h01);
      for (int i = 0; i < 9; i++) begin
         sw(1'b0, 8'h20 + i[7:0], 8'h00);
         chk(v, blk[i]);
      end
   endtask : status_check

   function automatic logic [7:0] fix(input int i, input logic [7:0] d);
      case (i)
         0: fix = d & 8'hf0 | 8'h01;
         1: fix = d & 8'h1d | 8'h02;
         2: fix = d & 8'hc0;
         3: fix = d & 8'h80;
         default: fix = d;
      endcase
   endfunction : fix

   always @(posedge clock) begin
      cyc++;
      if (tick) begin
         if (last > 0) chk(8'(cyc - last), 8'(FC));
         last = cyc;
      end
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      status_check();
      repeat (3) begin
         for (int i = 0; i < 9; i++) begin
            b = 8'($random(seed));
            if (i == 4) b = {1'b0, 3'(b[6:4] % 7), 1'b0, 3'(b[2:0] % 7)};
            sw(1'b1, i[7:0], b);
            blk[i] = fix(i, b);
         end
         run(8'h02);
         chk(w[4], 8'h00);
         repeat (4 * FC) @(posedge clock);
         chk(w[4], blk[4]);
         chk({6'h0, enc_en, dec_en}, {6'h0, blk[4][7:4] != 4'h0, blk[4][3:0] != 4'h0});
         chk({6'h0, tdm, ser},
             {6'h0, blk[0][6:5] inside {2'h1, 2'h2}, blk[0][6:5] == 2'h2});
         for (int i = 0; i < 9; i++) begin
            chk(w[i] & BLOCK_KEEP[i], blk[i] & BLOCK_KEEP[i]);
         end
         status_check();
      end
      summarize();
   end
endmodule : codec_control_status_mailbox_tb

/* verification/codec_mailbox_props.sv */
// Concurrent checks on the host port joining the two mailbox ends.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module codec_mailbox_props (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       irq_n
);
   // --------------------------------------------------------------
   // Handshake and layout properties
   // --------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire h2d = wr && addr == 8'h50;

   a_status_post: assert property (h2d && wdata == 8'h33 |-> ##[2:4] !irq_n)
      else $error("no ready interrupt after status request");
   a_irq_release: assert property (wr && addr == 8'h58 |=> irq_n)
      else $error("interrupt not released by host clear");
   a_code_legal: assert property (h2d |-> wdata inside {8'h31, 8'h33, 8'h35})
      else $error("unexpected host code");
   a_ack_quiet: assert property (h2d && wdata == 8'h35 |-> irq_n [*3])
      else $error("interrupt raised by acknowledge");
   a_word0_fixed: assert property (rd && addr == 8'h00 |=> rdata[3:0] == 4'h1)
      else $error("word 0 fixed bits wrong");
   a_word1_fixed: assert property (rd && addr == 8'h01 |=> rdata[7:5] == 3'h0 && rdata[1])
      else $error("word 1 fixed bits wrong");
   a_word2_fixed: assert property (rd && addr == 8'h02 |=> rdata[5:0] == 6'h00)
      else $error("word 2 fixed bits wrong");
   a_word3_fixed: assert property (rd && addr == 8'h03 |=> rdata[6:0] == 7'h00)
      else $error("word 3 fixed bits wrong");

   c_status_req: cover property (h2d && wdata == 8'h33);
   c_ctrl_req: cover property (h2d && wdata == 8'h31);
   c_irq: cover property ($fell(irq_n));
endmodule : codec_mailbox_props
